/* inc/hcfm_consts.svh */
// Constants of the channel fault monitor: figures, codes, default counts.
// Assumes a single 25 MHz clock; included by the monitor only.
`ifndef HCFM_CONSTS_SVH
`define HCFM_CONSTS_SVH
`define HCFM_CLK_HZ 25000000
`define HCFM_TOL_LOW_V 13'h0040
`define HCFM_TOL_7KV_V 13'h0080
`define HCFM_CODE_FAIL 16'h9999
`define HCFM_CODE_TRIP 16'h8888
`define HCFM_CODE_SD_CH 8'h66
`define HCFM_CODE_SD_V 16'h6666
`define HCFM_PERSIST_MS 8'hC8
`define HCFM_SLEW_V_PER_S 100
`define HCFM_SLEW_WIN_MS 100
`define HCFM_FLASH_MS 250
`define HCFM_LAST_ADDR 5'h10
`define HCFM_BAUD_FAST 300
`define HCFM_BAUD_SLOW 110
`define HCFM_OVERSAMPLE 16
`endif

/* inc/hcfm_pkg.sv */
// Types shared by the channel fault monitor modules.
// Assumes nothing beyond the constants header.
package hcfm_pkg;
   typedef enum logic [1:0] {
      HCFM_SEL_NONE,
      HCFM_SEL_ONE,
      HCFM_SEL_ALL
   } hcfm_sel_type;
endpackage : hcfm_pkg

/* hdl/hcfm_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is independent; multi-bit values may skew by a cycle.
`timescale 1ns/1ps
module hcfm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : hcfm_sync

/* hdl/hcfm_tick.sv */
// Divider giving a one-cycle enable every divisor cycles.
// Assumes the divisor may change at any time; it takes effect on reload.
`timescale 1ns/1ps
module hcfm_tick #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] divisor,
   output logic tick
);
   logic [W-1:0] cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt == '0) begin
         cnt <= divisor - W'(1);
         tick <= 1'b1;
      end else begin
         cnt <= cnt - W'(1);
         tick <= 1'b0;
      end
   end
endmodule : hcfm_tick

/* hdl/hcfm_monitor.sv */
// Channel fault supervision, local shutdown latch and chain presence logic.
// Assumes readings arrive from the scan controller on this clock; pins
// from switches, jumpers, the supply and the chain are asynchronous.
`timescale 1ns/1ps
`include "hcfm_consts.svh"
module hcfm_monitor import hcfm_pkg::*; #(
   parameter int NUM_CH = 32,
   parameter int VW = 13,
   parameter int MS_CYCLES = `HCFM_CLK_HZ / 1000,
   parameter int BAUD_FAST_DIV =
      `HCFM_CLK_HZ / (`HCFM_OVERSAMPLE * `HCFM_BAUD_FAST),
   parameter int BAUD_SLOW_DIV =
      `HCFM_CLK_HZ / (`HCFM_OVERSAMPLE * `HCFM_BAUD_SLOW)
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic HV_ON,
   input wire logic NORMAL_MODE,
   input wire logic RUNUP_LIMITED,
   input wire logic MEAS_STB,
   input wire logic [$clog2(NUM_CH)-1:0] MEAS_CH,
   input wire logic [VW-1:0] MEAS_VOLT,
   input wire logic [VW-1:0] DEMAND_VOLT,
   input wire logic [NUM_CH-1:0] POD_7KV,
   input wire logic [NUM_CH-1:0] TRIP_DEFEAT,
   input wire logic [NUM_CH-1:0] GANG_MASK,
   input wire logic [NUM_CH-1:0] TRIP_SENSE,
   input wire logic RESTORE_STB,
   input wire logic [$clog2(NUM_CH)-1:0] RESTORE_CH,
   input wire logic [$clog2(NUM_CH)-1:0] DISP_SEL,
   input wire logic OVER_TEMP,
   input wire logic OVER_VOLT,
   input wire logic POWER_OK,
   input wire logic [4:0] ADDR_SW,
   input wire logic LOCAL_SW,
   input wire logic BAUD_JMP_SLOW,
   input wire logic ADDR_STB,
   input wire logic [4:0] ADDR_VAL,
   input wire logic CMD_DONE,
   input wire logic TX_DATA,
   input wire logic CHAIN_FWD_IN,
   input wire logic CHAIN_RET_IN,
   output logic [NUM_CH-1:0] CH_FAILED,
   output logic [NUM_CH-1:0] CH_TRIPPED,
   output logic [7:0] DISP_CHAN,
   output logic [15:0] DISP_VAL,
   output logic DISP_OVERRIDE,
   output logic DISP_BLANK,
   output logic SHUTDOWN,
   output logic SUPPLY40_EN,
   output logic CONTROL_EN,
   output logic SELECTED,
   output logic RESPOND,
   output logic [4:0] ADDR_OUT,
   output logic ECHO_EN,
   output logic RX_DATA,
   output logic CHAIN_FWD_OUT,
   output logic CHAIN_RET_OUT,
   output logic BAUD_TICK,
   output logic BAUD_SLOW
);
   localparam int CW = $clog2(NUM_CH);
   localparam int SYW = NUM_CH + 11;
   localparam logic [VW:0] SLEW_MIN_V =
      (VW+1)'(`HCFM_SLEW_V_PER_S * `HCFM_SLEW_WIN_MS / 1000);

   if (NUM_CH < 2 || NUM_CH > 99 || VW < 9 || MS_CYCLES < 2
       || MS_CYCLES > 65535 || BAUD_SLOW_DIV > 65535) begin : bad_cfg
      $error("hcfm_monitor: unsupported parameter values");
   end

   logic [SYW-1:0] sync_out;
   logic [NUM_CH-1:0] trip_s;
   logic [4:0] addr_s;
   logic ot_s, ov_s, pwr_s, local_s, slow_s, fwd_s, ret_s;
   logic ms_tick;

   // Trip, address switch, supply, local, jumper and CHAIN_FWD_IN pins share one synchroniser; the trip inputs are edge-detected.
   hcfm_sync #(.W(SYW)) u_sync (
      .clk(CLOCK),
      .rstn(RSTN),
      .din({TRIP_SENSE, ADDR_SW, OVER_TEMP, OVER_VOLT, POWER_OK, LOCAL_SW,
            BAUD_JMP_SLOW, CHAIN_FWD_IN}),
      .dout(sync_out)
   );
   assign {trip_s, addr_s, ot_s, ov_s, pwr_s, local_s, slow_s, fwd_s} =
      sync_out;

   hcfm_sync #(.W(1)) u_sync_ret (
      .clk(CLOCK),
      .rstn(RSTN),
      .din(CHAIN_RET_IN),
      .dout(ret_s)
   );

   hcfm_tick #(.W(16)) u_ms (
      .clk(CLOCK),
      .rstn(RSTN),
      .divisor(16'(MS_CYCLES)),
      .tick(ms_tick)
   );

   // The jumper is read on every reload, so a change takes effect live.
   hcfm_tick #(.W(16)) u_baud (
      .clk(CLOCK),
      .rstn(RSTN),
      .divisor(slow_s ? 16'(BAUD_SLOW_DIV) : 16'(BAUD_FAST_DIV)),
      .tick(BAUD_TICK)
   );

   // Deviation of the current reading against its demand.
   logic [VW-1:0] diff, tol;
   logic dev, fast, meas_ok, fail_dev, slew_bad;
   logic [NUM_CH-1:0] dev_seen, due, armed, trip_q;
   logic [7:0] ms_cnt [NUM_CH];
   logic [VW-1:0] snap [NUM_CH];
   logic [6:0] win_cnt;
   logic slew_tick;

   always_comb begin
      diff = MEAS_VOLT >= DEMAND_VOLT ? MEAS_VOLT - DEMAND_VOLT
                                      : DEMAND_VOLT - MEAS_VOLT;
      tol = POD_7KV[MEAS_CH] ? VW'(`HCFM_TOL_7KV_V)
                             : VW'(`HCFM_TOL_LOW_V);
      meas_ok = MEAS_STB && HV_ON;
      dev = diff >= tol;
      fast = POD_7KV[MEAS_CH] && !TRIP_DEFEAT[MEAS_CH];
      fail_dev = meas_ok && dev && dev_seen[MEAS_CH]
         && (fast || ms_cnt[MEAS_CH] >= `HCFM_PERSIST_MS);
      slew_bad = meas_ok && RUNUP_LIMITED && POD_7KV[MEAS_CH]
         && due[MEAS_CH] && armed[MEAS_CH]
         && {1'b0, MEAS_VOLT} < {1'b0, snap[MEAS_CH]} + SLEW_MIN_V;
   end

   // Persistence filter: a reading back in tolerance starts over.
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         dev_seen <= '0;
         for (int i = 0; i < NUM_CH; i++) ms_cnt[i] <= 8'h00;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (!HV_ON) begin
               dev_seen[i] <= 1'b0;
               ms_cnt[i] <= 8'h00;
            end else if (RESTORE_STB && !sd && RESTORE_CH == CW'(i)) begin
               // Stale history would re-fail a restored channel at once.
               dev_seen[i] <= 1'b0;
               ms_cnt[i] <= 8'h00;
            end else if (MEAS_STB && MEAS_CH == CW'(i)) begin
               dev_seen[i] <= dev;
               if (!dev) ms_cnt[i] <= 8'h00;
            end else if (ms_tick && dev_seen[i] && ms_cnt[i] != 8'hFF) begin
               ms_cnt[i] <= ms_cnt[i] + 8'h01;
            end
         end
      end
   end

   // Run-up slew window: a snapshot per window, compared at the next one.
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         win_cnt <= 7'h00;
         slew_tick <= 1'b0;
      end else begin
         slew_tick <= ms_tick && win_cnt == 7'(`HCFM_SLEW_WIN_MS - 1);
         if (ms_tick) begin
            win_cnt <= win_cnt == 7'(`HCFM_SLEW_WIN_MS - 1) ? 7'h00
                                                        : win_cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         due <= '0;
         armed <= '0;
         for (int i = 0; i < NUM_CH; i++) snap[i] <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (!RUNUP_LIMITED || !HV_ON) begin
               due[i] <= 1'b0;
               armed[i] <= 1'b0;
            end else if (MEAS_STB && MEAS_CH == CW'(i)
                         && (due[i] || !armed[i])) begin
               snap[i] <= MEAS_VOLT;
               armed[i] <= 1'b1;
               due[i] <= slew_tick;
            end else if (slew_tick) begin
               due[i] <= 1'b1;
            end
         end
      end
   end

   // Fault flags: a new fault in the cycle of a restore still sets.
   logic [NUM_CH-1:0] trip_en, trip_edge, fail_set, trip_set, clr;
   logic gang_hit;
   logic sd;
   always_comb begin
      trip_en = POD_7KV & ~TRIP_DEFEAT;
      trip_edge = trip_s & ~trip_q & trip_en;
      gang_hit = |(trip_edge & GANG_MASK);
      trip_set = trip_edge;
      fail_set = trip_edge | (gang_hit ? GANG_MASK : '0);
      if (fail_dev || slew_bad) fail_set[MEAS_CH] = 1'b1;
      clr = '0;
      if (RESTORE_STB && !sd) clr[RESTORE_CH] = 1'b1;
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         trip_q <= '0;
         CH_FAILED <= '0;
         CH_TRIPPED <= '0;
      end else begin
         trip_q <= trip_s;
         CH_FAILED <= (CH_FAILED & ~clr) | fail_set;
         CH_TRIPPED <= (CH_TRIPPED & ~clr) | trip_set;
      end
   end

   // Local shutdown latch; only a power-on reset releases it.
   logic next_sd;
   assign next_sd = sd || (HV_ON && (ot_s || ov_s));
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         sd <= 1'b0;
         SHUTDOWN <= 1'b0;
         SUPPLY40_EN <= 1'b0;
         CONTROL_EN <= 1'b1;
      end else begin
         sd <= next_sd;
         SHUTDOWN <= next_sd;
         SUPPLY40_EN <= HV_ON && !next_sd;
         CONTROL_EN <= !next_sd;
      end
   end

   // Display codes; the flash period is a compromise of visibility.
   logic [7:0] flash_cnt;
   logic flash;
   logic [CW-1:0] tens;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         flash_cnt <= 8'h00;
         flash <= 1'b0;
      end else if (ms_tick) begin
         if (flash_cnt == 8'(`HCFM_FLASH_MS - 1)) begin
            flash_cnt <= 8'h00;
            flash <= !flash;
         end else begin
            flash_cnt <= flash_cnt + 8'h01;
         end
      end
   end

   assign tens = DISP_SEL / CW'(10);
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         DISP_CHAN <= 8'h00;
         DISP_VAL <= 16'h0000;
         DISP_OVERRIDE <= 1'b0;
         DISP_BLANK <= 1'b0;
      end else if (sd && NORMAL_MODE) begin
         DISP_CHAN <= `HCFM_CODE_SD_CH;
         DISP_VAL <= `HCFM_CODE_SD_V;
         DISP_OVERRIDE <= 1'b1;
         DISP_BLANK <= flash;
      end else begin
         DISP_CHAN <= {4'(tens), 4'(DISP_SEL - tens * CW'(10))};
         DISP_BLANK <= 1'b0;
         if (CH_TRIPPED[DISP_SEL]) begin
            DISP_VAL <= `HCFM_CODE_TRIP;
            DISP_OVERRIDE <= 1'b1;
         end else if (CH_FAILED[DISP_SEL]) begin
            DISP_VAL <= `HCFM_CODE_FAIL;
            DISP_OVERRIDE <= 1'b1;
         end else begin
            DISP_VAL <= 16'h0000;
            DISP_OVERRIDE <= 1'b0;
         end
      end
   end

   // Unit selection; local mode and shutdown freeze it as it stands.
   hcfm_sel_type sel;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         sel <= HCFM_SEL_NONE;
      end else if (!local_s && !sd) begin
         case (sel)
            HCFM_SEL_ALL: begin
               if (ADDR_STB) sel <= ADDR_VAL == 5'h00 ? HCFM_SEL_ALL
                  : (ADDR_VAL == addr_s ? HCFM_SEL_ONE : HCFM_SEL_NONE);
               else if (CMD_DONE) sel <= HCFM_SEL_NONE;
            end
            default: begin
               if (ADDR_STB) sel <= ADDR_VAL == 5'h00 ? HCFM_SEL_ALL
                  : (ADDR_VAL == addr_s ? HCFM_SEL_ONE
                  : HCFM_SEL_NONE);
            end
         endcase
      end
   end

   // Chain pass-through runs regardless of mode; a dead unit opens it.
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         SELECTED <= 1'b0;
         RESPOND <= 1'b0;
         ADDR_OUT <= 5'h00;
         ECHO_EN <= 1'b0;
         RX_DATA <= 1'b1;
         CHAIN_FWD_OUT <= 1'b0;
         CHAIN_RET_OUT <= 1'b0;
         BAUD_SLOW <= 1'b0;
      end else begin
         SELECTED <= sel == HCFM_SEL_ONE;
         RESPOND <= sel != HCFM_SEL_NONE && !local_s && !sd;
         ADDR_OUT <= addr_s;
         ECHO_EN <= addr_s == `HCFM_LAST_ADDR && !local_s && pwr_s;
         RX_DATA <= fwd_s;
         CHAIN_FWD_OUT <= pwr_s && fwd_s;
         CHAIN_RET_OUT <= pwr_s && (ECHO_EN ? fwd_s : ret_s)
            && (TX_DATA || !RESPOND);
         BAUD_SLOW <= slow_s;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   sequence sd_cause;
      HV_ON && (ot_s || ov_s);
   endsequence
   sequence gang_trip;
      |(trip_s & ~trip_q & trip_en & GANG_MASK);
   endsequence

   shutdown_entry_a: assert property (sd_cause |=> SHUTDOWN && !SUPPLY40_EN && !CONTROL_EN)
      else $error("shutdown not raised on supply fault");
   shutdown_hold_a: assert property (SHUTDOWN |=> SHUTDOWN ##1 SHUTDOWN)
      else $error("shutdown latch released");
   no_sd_hvoff_a: assert property (!HV_ON && !sd |=> !SHUTDOWN)
      else $error("shutdown raised with HV off");
   fail_code_a: assert property (!(sd && NORMAL_MODE) && CH_FAILED[DISP_SEL] && !CH_TRIPPED[DISP_SEL] |=> DISP_VAL == `HCFM_CODE_FAIL)
      else $error("failed channel not shown as 9999");
   trip_code_a: assert property (!(sd && NORMAL_MODE) && CH_TRIPPED[DISP_SEL] |=> DISP_VAL == `HCFM_CODE_TRIP)
      else $error("tripped channel not shown as 8888");
   gang_fail_a: assert property (gang_trip |=> (CH_FAILED & GANG_MASK) == GANG_MASK)
      else $error("ganged channels not failed together");
   flash_code_a: assert property (sd && NORMAL_MODE |=> DISP_CHAN == `HCFM_CODE_SD_CH && DISP_VAL == `HCFM_CODE_SD_V)
      else $error("shutdown pattern missing");
   restore_clr_a: assert property (RESTORE_STB && !sd && !fail_set[RESTORE_CH] |=> !CH_FAILED[$past(RESTORE_CH)])
      else $error("restore did not clear channel");
   reset_filter_a: assert property (MEAS_STB && HV_ON && !dev |=> !dev_seen[$past(MEAS_CH)] && ms_cnt[$past(MEAS_CH)] == 8'h00)
      else $error("deviation filter not reset");
   single_dev_a: assert property (meas_ok && dev && !dev_seen[MEAS_CH] |-> !fail_dev)
      else $error("single deviation failed channel");
   local_keep_a: assert property (local_s |=> $stable(sel))
      else $error("selection changed in local mode");
endmodule : hcfm_monitor

/* sim/hcfm_terminal.sv */
// Terminal model on the chain's current loop, sending and receiving 8N1.
// Assumes mark is 1 and the loop rests at mark between characters.
`timescale 1ns/1ps
module hcfm_terminal #(
   parameter int BIT_CYC = 64
) (
   input wire logic clk,
   input wire logic rx,
   output logic tx,
   output logic [7:0] last_rx
);
   initial begin
      tx = 1'h1;
      last_rx = 8'h00;
   end
   // The bit period is scaled down from 110 or 300 baud to keep runs short.
   task automatic send(input logic [7:0] ch);
      int i;
      @(posedge clk);
      tx <= 1'h0;
      repeat (BIT_CYC) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         tx <= ch[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      tx <= 1'h1;
      repeat (BIT_CYC) @(posedge clk);
   endtask : send
   always begin : receiver
      logic [7:0] d;
      int k;
      @(negedge rx);
      repeat (BIT_CYC / 2) @(posedge clk);
      // A low shorter than half a bit, such as a reset pulse, is no start.
      if (rx === 1'h0) begin
         for (k = 0; k < 8; k++) begin
            repeat (BIT_CYC) @(posedge clk);
            d[k] = rx;
         end
         repeat (BIT_CYC) @(posedge clk);
         last_rx = d;
      end
   end
endmodule : hcfm_terminal

/* sim/hcfm_monitor_tb.sv */
// Self-checking bench for the channel fault monitor and a terminal model.
// Assumes the shortened millisecond and baud divisors set at the instance.
`timescale 1ns/1ps
module hcfm_monitor_tb;
   localparam int MS = 10;
   localparam int BIT = 64;
   logic CLOCK = 1'h0, RSTN = 1'h0, HV_ON = 1'h1, NORMAL_MODE = 1'h1;
   logic RUNUP_LIMITED = 1'h0, MEAS_STB = 1'h0, RESTORE_STB = 1'h0;
   logic [4:0] MEAS_CH = 5'h00, RESTORE_CH = 5'h00, DISP_SEL = 5'h1F;
   logic [12:0] MEAS_VOLT = 13'h0000, DEMAND_VOLT = 13'h0000;
   logic [31:0] POD_7KV = 32'h00000027, GANG_MASK = 32'h00000005;
   logic [31:0] TRIP_DEFEAT = 32'h0, TRIP_SENSE = 32'h0;
   logic OVER_TEMP = 1'h0, OVER_VOLT = 1'h0, POWER_OK = 1'h1;
   logic [4:0] ADDR_SW = 5'h05, ADDR_VAL = 5'h00;
   logic LOCAL_SW = 1'h0, BAUD_JMP_SLOW = 1'h0, ADDR_STB = 1'h0;
   logic CMD_DONE = 1'h0, TX_DATA = 1'h1, CHAIN_RET_IN = 1'h1;
   logic pick_fwd = 1'h0;
   logic CHAIN_FWD_IN, term_rx;
   logic [7:0] term_last;
   logic [31:0] CH_FAILED, CH_TRIPPED;
   logic [7:0] DISP_CHAN;
   logic [15:0] DISP_VAL;
   logic [4:0] ADDR_OUT;
   logic DISP_OVERRIDE, DISP_BLANK, SHUTDOWN, SUPPLY40_EN, CONTROL_EN;
   logic SELECTED, RESPOND, ECHO_EN, RX_DATA, CHAIN_FWD_OUT, CHAIN_RET_OUT;
   logic BAUD_TICK, BAUD_SLOW;
   int errors = 0;
   int total_checks = 0;

   always #20 CLOCK = ~CLOCK;
   assign term_rx = pick_fwd ? CHAIN_FWD_OUT : CHAIN_RET_OUT;

   hcfm_monitor #(.NUM_CH(32), .VW(13), .MS_CYCLES(MS),
      .BAUD_FAST_DIV(16), .BAUD_SLOW_DIV(40)) i_hcfm_monitor (
      .CLOCK(CLOCK), .RSTN(RSTN), .HV_ON(HV_ON), .NORMAL_MODE(NORMAL_MODE),
      .RUNUP_LIMITED(RUNUP_LIMITED), .MEAS_STB(MEAS_STB), .MEAS_CH(MEAS_CH),
      .MEAS_VOLT(MEAS_VOLT), .DEMAND_VOLT(DEMAND_VOLT), .POD_7KV(POD_7KV),
      .TRIP_DEFEAT(TRIP_DEFEAT), .GANG_MASK(GANG_MASK),
      .TRIP_SENSE(TRIP_SENSE), .RESTORE_STB(RESTORE_STB),
      .RESTORE_CH(RESTORE_CH), .DISP_SEL(DISP_SEL), .OVER_TEMP(OVER_TEMP),
      .OVER_VOLT(OVER_VOLT), .POWER_OK(POWER_OK), .ADDR_SW(ADDR_SW),
      .LOCAL_SW(LOCAL_SW), .BAUD_JMP_SLOW(BAUD_JMP_SLOW),
      .ADDR_STB(ADDR_STB), .ADDR_VAL(ADDR_VAL), .CMD_DONE(CMD_DONE),
      .TX_DATA(TX_DATA), .CHAIN_FWD_IN(CHAIN_FWD_IN),
      .CHAIN_RET_IN(CHAIN_RET_IN), .CH_FAILED(CH_FAILED),
      .CH_TRIPPED(CH_TRIPPED), .DISP_CHAN(DISP_CHAN), .DISP_VAL(DISP_VAL),
      .DISP_OVERRIDE(DISP_OVERRIDE), .DISP_BLANK(DISP_BLANK),
      .SHUTDOWN(SHUTDOWN), .SUPPLY40_EN(SUPPLY40_EN),
      .CONTROL_EN(CONTROL_EN), .SELECTED(SELECTED), .RESPOND(RESPOND),
      .ADDR_OUT(ADDR_OUT), .ECHO_EN(ECHO_EN), .RX_DATA(RX_DATA),
      .CHAIN_FWD_OUT(CHAIN_FWD_OUT), .CHAIN_RET_OUT(CHAIN_RET_OUT),
      .BAUD_TICK(BAUD_TICK), .BAUD_SLOW(BAUD_SLOW));

   hcfm_terminal #(.BIT_CYC(BIT)) i_hcfm_terminal (
      .clk(CLOCK), .rx(term_rx), .tx(CHAIN_FWD_IN), .last_rx(term_last));

   task automatic final_report;
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Inputs change 1 ns after an edge, so outputs are read settled.
   task automatic step(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : step

   task automatic meas(input logic [4:0] c, input logic [12:0] v,
                       input logic [12:0] d);
      MEAS_CH <= c;
      MEAS_VOLT <= v;
      DEMAND_VOLT <= d;
      MEAS_STB <= 1'h1;
      step(1);
      MEAS_STB <= 1'h0;
      step(1);
   endtask : meas

   task automatic restore(input logic [4:0] c);
      RESTORE_CH <= c;
      RESTORE_STB <= 1'h1;
      step(1);
      RESTORE_STB <= 1'h0;
      step(1);
   endtask : restore

   task automatic addr(input logic [4:0] v);
      ADDR_VAL <= v;
      ADDR_STB <= 1'h1;
      step(1);
      ADDR_STB <= 1'h0;
      step(2);
   endtask : addr

   task automatic do_reset;
      RSTN <= 1'h0;
      step(16);
      RSTN <= 1'h1;
      step(3);
   endtask : do_reset

   task automatic t_fast;
      meas(5'h01, 13'h467, 13'h3E8);
      meas(5'h01, 13'h467, 13'h3E8);
      cmp(CH_FAILED[1], 1'h0);
      meas(5'h01, 13'h368, 13'h3E8);
      meas(5'h01, 13'h3E8, 13'h3E8);
      meas(5'h01, 13'h368, 13'h3E8);
      cmp(CH_FAILED[1], 1'h0);
      meas(5'h01, 13'h368, 13'h3E8);
      cmp(CH_FAILED[1], 1'h1);
      DISP_SEL <= 5'h01;
      step(3);
      cmp({DISP_OVERRIDE, DISP_VAL}, 17'h19999);
      restore(5'h01);
      cmp(CH_FAILED[1], 1'h0);
   endtask : t_fast

   task automatic t_slow;
      meas(5'h03, 13'h427, 13'h3E8);
      meas(5'h03, 13'h427, 13'h3E8);
      meas(5'h03, 13'h428, 13'h3E8);
      meas(5'h03, 13'h428, 13'h3E8);
      cmp(CH_FAILED[3], 1'h0);
      step(210 * MS);
      meas(5'h03, 13'h428, 13'h3E8);
      cmp(CH_FAILED[3], 1'h1);
      restore(5'h03);
      TRIP_DEFEAT[1] <= 1'h1;
      meas(5'h01, 13'h368, 13'h3E8);
      meas(5'h01, 13'h368, 13'h3E8);
      cmp(CH_FAILED[1], 1'h0);
      meas(5'h01, 13'h3E8, 13'h3E8);
      TRIP_DEFEAT[1] <= 1'h0;
   endtask : t_slow

   task automatic t_slew;
      int i;
      RUNUP_LIMITED <= 1'h1;
      // A stalled output 50 V short of demand stays inside tolerance.
      for (i = 0; i < 30; i++) begin
         meas(5'h05, 13'h3E8, 13'h41A);
         step(10 * MS - 2);
      end
      cmp(CH_FAILED[5], 1'h1);
      RUNUP_LIMITED <= 1'h0;
      restore(5'h05);
   endtask : t_slew

   task automatic t_trip;
      TRIP_SENSE[0] <= 1'h1;
      step(5);
      cmp({CH_TRIPPED[2:0], CH_FAILED[2:0]}, 6'h0D);
      DISP_SEL <= 5'h00;
      step(3);
      cmp(DISP_VAL, 16'h8888);
      DISP_SEL <= 5'h02;
      step(3);
      cmp(DISP_VAL, 16'h9999);
      TRIP_SENSE[0] <= 1'h0;
      step(4);
   endtask : t_trip

   task automatic t_select;
      addr(5'h05);
      cmp(SELECTED, 1'h1);
      ADDR_SW <= 5'h07;
      step(4);
      cmp({SELECTED, ADDR_OUT}, 6'h27);
      LOCAL_SW <= 1'h1;
      step(4);
      LOCAL_SW <= 1'h0;
      step(4);
      cmp(SELECTED, 1'h1);
      addr(5'h03);
      cmp(SELECTED, 1'h0);
      addr(5'h00);
      cmp({SELECTED, RESPOND}, 2'h1);
      CMD_DONE <= 1'h1;
      step(1);
      CMD_DONE <= 1'h0;
      step(2);
      cmp({SELECTED, RESPOND}, 2'h0);
   endtask : t_select

   // Three gaps are timed so a divisor change has reloaded before the last.
   task automatic tick_gap(output int n);
      int k;
      for (k = 0; k < 3; k++) begin
         n = 0;
         step(1);
         while (BAUD_TICK !== 1'h1) begin
            step(1);
            n++;
            if (n > 200) begin
               errors++;
               final_report();
            end
         end
      end
   endtask : tick_gap

   // Steps until the flash phase changes; n is the length of the phase.
   task automatic blank_gap(output int n);
      logic b;
      b = DISP_BLANK;
      n = 0;
      while (DISP_BLANK === b) begin
         step(1);
         n++;
         if (n > 2700) begin
            errors++;
            final_report();
         end
      end
   endtask : blank_gap

   task automatic t_baud;
      int n;
      step(4);
      tick_gap(n);
      cmp({BAUD_SLOW, n[7:0]}, 9'h00F);
      BAUD_JMP_SLOW <= 1'h1;
      step(4);
      tick_gap(n);
      cmp({BAUD_SLOW, n[7:0]}, 9'h127);
   endtask : t_baud

   task automatic t_chain;
      ADDR_SW <= 5'h10;
      step(4);
      cmp({ECHO_EN, RX_DATA}, 2'h3);
      i_hcfm_terminal.send(8'h4D);
      step(BIT);
      cmp(term_last, 8'h4D);
      addr(5'h10);
      TX_DATA <= 1'h0;
      step(2);
      cmp(CHAIN_RET_OUT, 1'h0);
      TX_DATA <= 1'h1;
      step(2);
      ADDR_SW <= 5'h05;
      LOCAL_SW <= 1'h1;
      pick_fwd <= 1'h1;
      step(4);
      cmp(ECHO_EN, 1'h0);
      i_hcfm_terminal.send(8'h31);
      step(BIT);
      cmp(term_last, 8'h31);
      LOCAL_SW <= 1'h0;
   endtask : t_chain

   task automatic t_shutdown;
      int n;
      HV_ON <= 1'h0;
      OVER_TEMP <= 1'h1;
      step(5);
      cmp(SHUTDOWN, 1'h0);
      HV_ON <= 1'h1;
      step(5);
      cmp({SHUTDOWN, SUPPLY40_EN, CONTROL_EN}, 3'h4);
      OVER_TEMP <= 1'h0;
      step(5);
      cmp({SHUTDOWN, SUPPLY40_EN, CONTROL_EN}, 3'h4);
      cmp({DISP_CHAN, DISP_VAL}, 24'h666666);
      blank_gap(n);
      blank_gap(n);
      cmp(n, 250 * MS);
      NORMAL_MODE <= 1'h0;
      restore(5'h02);
      step(1);
      cmp({DISP_CHAN, DISP_VAL}, 24'h029999);
      cmp(CH_FAILED[2], 1'h1);
      NORMAL_MODE <= 1'h1;
      do_reset();
      cmp({SHUTDOWN, CONTROL_EN}, 2'h1);
      OVER_VOLT <= 1'h1;
      step(5);
      cmp(SHUTDOWN, 1'h1);
   endtask : t_shutdown

   initial begin
      do_reset();
      t_fast();
      t_slow();
      t_slew();
      t_trip();
      t_select();
      t_baud();
      t_chain();
      t_shutdown();
      POWER_OK <= 1'h0;
      step(5);
      cmp({CHAIN_FWD_OUT, CHAIN_RET_OUT}, 2'h0);
      final_report();
   end
endmodule : hcfm_monitor_tb
